// [ljr_chan_rst.sv]
// Purpose: per-channel software reset sequencer
// Assumes: start is a one-cycle pulse from the register write decode
// Notes: a start while busy restarts the count

`timescale 1ns/1ps
`default_nettype none

module ljr_chan_rst #(
    parameter int CYCLES = ljr_pkg::CHANNEL_SOFT_RESET_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // control
    input wire logic start_in,
    // status
    output logic busy_out,
    output logic done_out
);

    generate
        if (CYCLES < 1 || CYCLES > 255) begin : g_bad
            $error("ljr_chan_rst: CYCLES must be 1..255");
        end
    endgenerate

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic end_w;

    // busy from start until the count runs out
    assign end_w = busy_out && (cnt_r == 8'h01) && !start_in;
    assign cnt_nxt = start_in ? 8'(CYCLES) : (busy_out ? cnt_r - 8'h01 : 8'h00);

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= 8'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_out <= start_in || (busy_out && !end_w); // R6 R7
            done_out <= end_w;
        end
    end

endmodule

`default_nettype wire

// [ljr_host.sv]
// Purpose: host processor model on the register port
// Assumes: one-cycle strobes, read data in the cycle after the strobe
// Notes: released address and data lines flip so stale values are never reused
`timescale 1ns/1ps
`default_nettype none
module ljr_host (
    // clock
    input wire logic sys_clk_in,
    // register port
    output logic [10:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in
);
    // idle bus at time zero
    initial begin
        reg_addr_out = 11'h000;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end
    // one-cycle write
    task automatic wr_reg(input logic [10:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask
    // one-cycle read, data taken one cycle after the strobe
    task automatic rd_reg(input logic [10:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        @(posedge sys_clk_in);
        d = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

// [ljr_pkg.sv]
// Purpose: constants and decode helpers for the line interface register bank
// Assumes: 22 channels (0..21), 11-bit byte address, 8-bit data, 20 MHz clock
// Notes: channel n (1..21) owns block n-1 at stride 0x40, channel 0 owns 0x7c0
// What this block does
// (R1) 0x340 bits 4:0 summarise channels 21..17
// (R2) 0x380 bit 7 summarises channel 0
// (R3) 0x3c0 bit 0 holds second-timer flag
// (R4) timer flag sets on expiry, write-one clears
// (R5) writing 1 to bit 1 resets one channel
// (R6) channel reset completes within 1 us
// (R7) channel reset bit clears itself when done
// (R8) attenuator config register per channel at +2
// (R9) attenuator config resets zero, read/write, 7:5 reserved
// (R10) bit 3 enables transmit jitter attenuator
// (R11) bits 2:1 pick fifo 128/64/32 bits
// (R12) bit 0 picks corner 6.77 or 0.87 Hz
// (R13) bit 4 enables fill-limit rate adjustment
// (R14) 0x300 bits 7:0 summarise channels 16..9
// (R15) channel flag is OR of its sources

package ljr_pkg;

    localparam int NCH = 22;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int TJA_W = 5;

    // register offsets
    localparam logic [10:0] OFF_SUM_LOW = 11'h2c0;
    localparam logic [10:0] OFF_SUM_MID = 11'h300;
    localparam logic [10:0] OFF_SUM_UP = 11'h340;
    localparam logic [10:0] OFF_SUM_CH0 = 11'h380;
    localparam logic [10:0] OFF_TIMER = 11'h3c0;
    localparam logic [10:0] OFF_EVT_STAT = 11'h7e0;
    localparam logic [10:0] OFF_EVT_MASK = 11'h7e4;
    localparam logic [5:0] SUB_CFG = 6'h01;
    localparam logic [5:0] SUB_TJA = 6'h02;
    localparam logic [4:0] CH0_BLOCK = 5'h1f;
    localparam logic [4:0] LAST_BLOCK = 5'h14;

    // field positions
    localparam int TX_ATTEN_CORNER_SELECT_BIT = 0;
    localparam int TJA_DP_LSB = 1;
    localparam int TX_ATTEN_ENABLE_BIT = 3;
    localparam int TJA_LIM_BIT = 4;
    localparam int CHANNEL_SOFT_RESET_BIT = 1;
    localparam int TMOV_BIT = 0;
    localparam int CHAN_ZERO_IRQ_FLAG_BIT = 7;
    localparam int EVT_TMR_BIT = 0;
    localparam int EVT_CHAN_BIT = 1;
    localparam int EVT_RST_BIT = 2;
    localparam int EVT_W = 3;

    // reset values
    localparam logic [4:0] TJA_RST = 5'h00;
    localparam logic [2:0] EVT_MASK_RST = 3'h0;

    // timing
    localparam int CLK_NS = 50;
    localparam int CHANNEL_SOFT_RESET_MAX_NS = 1000;
    localparam int CHANNEL_SOFT_RESET_CYC = CHANNEL_SOFT_RESET_MAX_NS / CLK_NS; // longest time, rounded down
    localparam int SEC_NS = 1000000000;
    localparam int SEC_CYC = SEC_NS / CLK_NS;

    // channel number owning an address (valid only with chan_block_ok)
    function automatic logic [4:0] chan_of(input logic [10:0] addr);
        chan_of = (addr[10:6] == CH0_BLOCK) ? 5'h00 : 5'(addr[10:6] + 5'h01);
    endfunction

    function automatic logic chan_block_ok(input logic [10:0] addr);
        chan_block_ok = (addr[10:6] <= LAST_BLOCK) || (addr[10:6] == CH0_BLOCK);
    endfunction

    // fifo size in bits from the depth field
    function automatic logic [7:0] fifo_bits(input logic [1:0] dp);
        fifo_bits = dp[1] ? 8'h20 : (dp[0] ? 8'h40 : 8'h80);
    endfunction

endpackage

// [ljr_regs.sv]
// Purpose: register bank for interrupt summaries, second timer and per-channel
//          reset and transmit jitter attenuator configuration
// Assumes: plain register port, read data valid the cycle after the read strobe
// Notes: channel source inputs come from same-clock logic, already gated by
//        their own enables; irq_out is high while an unmasked event is set
//
// Added by the designer: the plain strobed port.

`timescale 1ns/1ps
`default_nettype none

module ljr_regs #(
    parameter int NSRC = 4,
    parameter int SEC_CYCLES = ljr_pkg::SEC_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,

    // register port
    input wire logic [10:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,

    // per-channel interrupt sources, channel c in bits c*NSRC +: NSRC
    input wire logic [ljr_pkg::NCH*NSRC-1:0] chan_irq_src_in,

    // transmit jitter attenuator controls, one bit or field per channel
    output logic [ljr_pkg::NCH-1:0] tx_atten_enable_out,
    output logic [2*ljr_pkg::NCH-1:0] tx_atten_fifo_depth_out,
    output logic [8*ljr_pkg::NCH-1:0] tx_atten_fifo_bits_out,
    output logic [ljr_pkg::NCH-1:0] tx_atten_corner_select_out,
    output logic [ljr_pkg::NCH-1:0] tx_atten_fill_limit_out,

    // per-channel soft reset to channel logic
    output logic [ljr_pkg::NCH-1:0] channel_soft_reset_out,

    // summary and interrupt
    output logic [ljr_pkg::NCH-1:0] chan_irq_flag_out,
    output logic irq_out
);

    localparam int NCH = ljr_pkg::NCH;
    localparam int TW = ljr_pkg::TJA_W;

    generate
        if (NSRC < 1) begin : g_bad_src
            $error("ljr_regs: NSRC must be at least 1");
        end
        if (SEC_CYCLES < 2) begin : g_bad_sec
            $error("ljr_regs: SEC_CYCLES must be at least 2");
        end
    endgenerate

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic [4:0] acc_chan_w;
    logic acc_chan_ok_w;
    logic [5:0] acc_sub_w;
    logic hit_sum_low_w;
    logic hit_sum_mid_w;
    logic hit_sum_up_w;
    logic hit_sum_ch0_w;
    logic hit_timer_w;
    logic hit_evt_stat_w;
    logic hit_evt_mask_w;
    logic hit_global_w;
    logic hit_cfg_w;
    logic hit_tja_w;

    // global registers first, then the per-channel blocks
    assign hit_sum_low_w = (reg_addr_in == ljr_pkg::OFF_SUM_LOW);
    assign hit_sum_mid_w = (reg_addr_in == ljr_pkg::OFF_SUM_MID);
    assign hit_sum_up_w = (reg_addr_in == ljr_pkg::OFF_SUM_UP);
    assign hit_sum_ch0_w = (reg_addr_in == ljr_pkg::OFF_SUM_CH0);
    assign hit_timer_w = (reg_addr_in == ljr_pkg::OFF_TIMER);
    assign hit_evt_stat_w = (reg_addr_in == ljr_pkg::OFF_EVT_STAT);
    assign hit_evt_mask_w = (reg_addr_in == ljr_pkg::OFF_EVT_MASK);
    assign hit_global_w = hit_sum_low_w | hit_sum_mid_w | hit_sum_up_w | hit_sum_ch0_w
        | hit_timer_w | hit_evt_stat_w | hit_evt_mask_w;

    // channel block decode
    assign acc_chan_w = ljr_pkg::chan_of(reg_addr_in);
    assign acc_chan_ok_w = ljr_pkg::chan_block_ok(reg_addr_in) && !hit_global_w;
    assign acc_sub_w = reg_addr_in[5:0];
    assign hit_cfg_w = acc_chan_ok_w && (acc_sub_w == ljr_pkg::SUB_CFG);
    assign hit_tja_w = acc_chan_ok_w && (acc_sub_w == ljr_pkg::SUB_TJA); // R8

    // ------------------------------------------------------------------
    // channel interrupt summaries
    // ------------------------------------------------------------------
    logic [NCH-1:0] chan_flag_w;
    logic [NCH-1:0] chan_flag_prev_r;
    logic chan_rise_w;

    // each channel flag follows its sources and drops when all clear
    genvar gs;
    generate
        for (gs = 0; gs < NCH; gs++) begin : g_sum
            assign chan_flag_w[gs] = |chan_irq_src_in[gs*NSRC +: NSRC]; // R15
        end
    endgenerate

    assign chan_irq_flag_out = chan_flag_w;
    assign chan_rise_w = |(chan_flag_w & ~chan_flag_prev_r);

    // remember flags to see new channel interrupts
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            chan_flag_prev_r <= '0;
        end else begin
            chan_flag_prev_r <= chan_flag_w;
        end
    end

    // ------------------------------------------------------------------
    // one-second timer and its status flag
    // ------------------------------------------------------------------
    logic sec_tick_w;
    logic tmov_r;
    logic tmov_nxt;
    logic tmov_clr_w;

    ljr_sec_timer #(
        .CYCLES(SEC_CYCLES)
    ) u_sec_timer (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_out(sec_tick_w)
    );

    // write one clears, a tick in the same cycle wins
    assign tmov_clr_w = reg_wr_in && hit_timer_w && reg_wdata_in[ljr_pkg::TMOV_BIT]; // R4
    assign tmov_nxt = sec_tick_w || (tmov_r && !tmov_clr_w); // R4

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tmov_r <= 1'b0;
        end else begin
            tmov_r <= tmov_nxt;
        end
    end

    // ------------------------------------------------------------------
    // per-channel soft reset and attenuator configuration
    // ------------------------------------------------------------------
    logic [NCH-1:0] rst_start_w;
    logic [NCH-1:0] rst_busy_w;
    logic [NCH-1:0] rst_done_w;
    logic [NCH-1:0] tja_we_w;
    logic [TW*NCH-1:0] tja_flat_w;
    logic rst_any_done_w;

    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++) begin : g_chan
            logic [TW-1:0] tja_r;
            logic [TW-1:0] tja_nxt;

            // a one in the reset bit starts this channel only, zero does nothing
            assign rst_start_w[gc] = reg_wr_in && hit_cfg_w && (acc_chan_w == 5'(gc))
                && reg_wdata_in[ljr_pkg::CHANNEL_SOFT_RESET_BIT]; // R5
            assign tja_we_w[gc] = reg_wr_in && hit_tja_w && (acc_chan_w == 5'(gc));

            ljr_chan_rst #(
                .CYCLES(ljr_pkg::CHANNEL_SOFT_RESET_CYC)
            ) u_chan_rst (
                .sys_clk_in(sys_clk_in),
                .sys_rst_in(sys_rst_in),
                .start_in(rst_start_w[gc]),
                .busy_out(rst_busy_w[gc]),
                .done_out(rst_done_w[gc])
            );

            // channel reset returns the config to default, writes otherwise load
            assign tja_nxt = rst_busy_w[gc] ? ljr_pkg::TJA_RST
                : (tja_we_w[gc] ? reg_wdata_in[TW-1:0] : tja_r); // R9

            always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    tja_r <= ljr_pkg::TJA_RST; // R9
                end else begin
                    tja_r <= tja_nxt;
                end
            end

            assign tja_flat_w[gc*TW +: TW] = tja_r;

            // attenuator controls straight from the config flops
            assign tx_atten_enable_out[gc] = tja_r[ljr_pkg::TX_ATTEN_ENABLE_BIT]; // R10
            assign tx_atten_fifo_depth_out[2*gc +: 2] = tja_r[ljr_pkg::TJA_DP_LSB +: 2]; // R11
            assign tx_atten_fifo_bits_out[8*gc +: 8] =
                ljr_pkg::fifo_bits(tja_r[ljr_pkg::TJA_DP_LSB +: 2]); // R11
            assign tx_atten_corner_select_out[gc] = tja_r[ljr_pkg::TX_ATTEN_CORNER_SELECT_BIT]; // R12
            assign tx_atten_fill_limit_out[gc] = tja_r[ljr_pkg::TJA_LIM_BIT]; // R13
        end
    endgenerate

    assign channel_soft_reset_out = rst_busy_w; // R6
    assign rst_any_done_w = |rst_done_w;

    // ------------------------------------------------------------------
    // event status, mask and interrupt output
    // ------------------------------------------------------------------
    logic [ljr_pkg::EVT_W-1:0] evt_stat_r;
    logic [ljr_pkg::EVT_W-1:0] evt_stat_nxt;
    logic [ljr_pkg::EVT_W-1:0] evt_set_w;
    logic [ljr_pkg::EVT_W-1:0] evt_mask_r;
    logic [ljr_pkg::EVT_W-1:0] evt_mask_nxt;
    logic evt_rd_clr_w;

    // gather events
    assign evt_set_w[ljr_pkg::EVT_TMR_BIT] = sec_tick_w;
    assign evt_set_w[ljr_pkg::EVT_CHAN_BIT] = chan_rise_w;
    assign evt_set_w[ljr_pkg::EVT_RST_BIT] = rst_any_done_w;

    // a read clears the status, an event in the same cycle survives
    assign evt_rd_clr_w = reg_rd_in && hit_evt_stat_w;
    assign evt_stat_nxt = evt_set_w | (evt_rd_clr_w ? '0 : evt_stat_r);
    assign evt_mask_nxt = (reg_wr_in && hit_evt_mask_w)
        ? reg_wdata_in[ljr_pkg::EVT_W-1:0] : evt_mask_r;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            evt_stat_r <= '0;
            evt_mask_r <= ljr_pkg::EVT_MASK_RST;
        end else begin
            evt_stat_r <= evt_stat_nxt;
            evt_mask_r <= evt_mask_nxt;
        end
    end

    assign irq_out = |(evt_stat_r & evt_mask_r);

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [7:0] rd_sum_low_w;
    logic [7:0] rd_sum_mid_w;
    logic [7:0] rd_sum_up_w;
    logic [7:0] rd_sum_ch0_w;
    logic [7:0] rd_timer_w;
    logic [7:0] rd_evt_stat_w;
    logic [7:0] rd_evt_mask_w;
    logic [7:0] rd_cfg_w;
    logic [7:0] rd_tja_w;
    logic [7:0] rd_sel_w;
    logic [7:0] rd_data_nxt;
    logic acc_chan_in_w;
    logic [TW-1:0] acc_tja_w;
    logic acc_busy_w;

    // summary words, reserved bits read zero
    assign rd_sum_low_w = chan_flag_w[8:1];
    assign rd_sum_mid_w = chan_flag_w[16:9]; // R14
    assign rd_sum_up_w = {3'h0, chan_flag_w[21:17]}; // R1
    assign rd_sum_ch0_w = {chan_flag_w[0], 7'h00}; // R2
    assign rd_timer_w = {7'h00, tmov_r}; // R3
    assign rd_evt_stat_w = {5'h00, evt_stat_r};
    assign rd_evt_mask_w = {5'h00, evt_mask_r};

    // selected channel's state, guarded against unused blocks
    assign acc_chan_in_w = acc_chan_ok_w && (acc_chan_w < 5'(NCH));
    assign acc_tja_w = acc_chan_in_w ? tja_flat_w[int'(acc_chan_w)*TW +: TW] : '0;
    assign acc_busy_w = acc_chan_in_w ? rst_busy_w[acc_chan_w] : 1'b0;
    assign rd_cfg_w = {6'h00, acc_busy_w, 1'b0}; // R7
    assign rd_tja_w = {3'h0, acc_tja_w}; // R9

    // one word per address, unmapped reads give zero
    assign rd_sel_w = hit_sum_low_w ? rd_sum_low_w
        : hit_sum_mid_w ? rd_sum_mid_w
        : hit_sum_up_w ? rd_sum_up_w
        : hit_sum_ch0_w ? rd_sum_ch0_w
        : hit_timer_w ? rd_timer_w
        : hit_evt_stat_w ? rd_evt_stat_w
        : hit_evt_mask_w ? rd_evt_mask_w
        : hit_cfg_w ? rd_cfg_w
        : hit_tja_w ? rd_tja_w
        : 8'h00;
    assign rd_data_nxt = reg_rd_in ? rd_sel_w : 8'h00;

    // read data stands for the cycle after the strobe only
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= rd_data_nxt;
        end
    end

endmodule

`default_nettype wire

// [ljr_regs_sva.sv]
// Purpose: port-level checks of the register bank
// Assumes: one clock domain, bound to ljr_regs
// Notes: soft reset length is counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module ljr_regs_sva #(
    parameter int NSRC = 4,
    parameter int SEC_CYCLES = 50
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [10:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // sources and controls
    input wire logic [ljr_pkg::NCH*NSRC-1:0] chan_irq_src_in,
    input wire logic [ljr_pkg::NCH-1:0] tx_atten_enable_out,
    input wire logic [2*ljr_pkg::NCH-1:0] tx_atten_fifo_depth_out,
    input wire logic [8*ljr_pkg::NCH-1:0] tx_atten_fifo_bits_out,
    input wire logic [ljr_pkg::NCH-1:0] tx_atten_corner_select_out,
    input wire logic [ljr_pkg::NCH-1:0] tx_atten_fill_limit_out,
    input wire logic [ljr_pkg::NCH-1:0] channel_soft_reset_out,
    // summary and interrupt
    input wire logic [ljr_pkg::NCH-1:0] chan_irq_flag_out,
    input wire logic irq_out
);
    logic [21:0] or_v;
    logic [5:0] cnt_r;
    wire logic start = reg_wr_in && reg_addr_in[5:0] == 6'h01 && reg_wdata_in[1];
    wire logic [4:0] cfg0 = {tx_atten_fill_limit_out[0], tx_atten_enable_out[0],
        tx_atten_fifo_depth_out[1:0], tx_atten_corner_select_out[0]};
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // expected flags from raw sources
    always_comb begin
        for (int c = 0; c < ljr_pkg::NCH; c++) begin
            or_v[c] = |chan_irq_src_in[c*NSRC +: NSRC];
        end
    end
    // cycles since latest soft reset start, saturating
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= 6'h00;
        end else if (start) begin
            cnt_r <= 6'h00;
        end else if (cnt_r != 6'h3f) begin
            cnt_r <= cnt_r + 6'h01;
        end
    end
    AST_FLAG_OR: assert property (chan_irq_flag_out == or_v)
        else $error("channel flag not the or of its sources");
    AST_SUM_UP: assert property (reg_rd_in && reg_addr_in == 11'h340 |=>
        reg_rdata_out == {3'h0, $past(chan_irq_flag_out[21:17])})
        else $error("upper summary read wrong");
    AST_SUM_CH0: assert property (reg_rd_in && reg_addr_in == 11'h380 |=>
        reg_rdata_out == {$past(chan_irq_flag_out[0]), 7'h00})
        else $error("channel zero summary read wrong");
    AST_SUM_MID: assert property (reg_rd_in && reg_addr_in == 11'h300 |=>
        reg_rdata_out == $past(chan_irq_flag_out[16:9]))
        else $error("middle summary read wrong");
    AST_TMR_RSV: assert property (reg_rd_in && reg_addr_in == 11'h3c0 |=>
        reg_rdata_out[7:1] == 7'h00)
        else $error("timer register reserved bits set");
    AST_RST_START: assert property (start && reg_addr_in[10:6] <= 5'h14 |=>
        channel_soft_reset_out[$past(reg_addr_in[10:6]) + 5'h01])
        else $error("soft reset did not start");
    AST_RST_QUIET: assert property (channel_soft_reset_out == '0 && !start |=>
        channel_soft_reset_out == '0)
        else $error("soft reset without a start");
    AST_RST_LEN: assert property (|channel_soft_reset_out |-> cnt_r < 6'd20)
        else $error("soft reset longer than allowed");
    AST_TJA_WR: assert property (reg_wr_in && reg_addr_in == 11'h7c2 &&
        !channel_soft_reset_out[0] |=> cfg0 == $past(reg_wdata_in[4:0]))
        else $error("attenuator config not written");
    AST_TJA_RD: assert property (reg_rd_in && reg_addr_in == 11'h7c2 |=>
        reg_rdata_out == {3'h0, $past(cfg0)})
        else $error("attenuator config read wrong");
    AST_FIFO: assert property (tx_atten_fifo_bits_out[7:0] ==
        (cfg0[2] ? 8'h20 : (cfg0[1] ? 8'h40 : 8'h80)))
        else $error("fifo size decode wrong");
endmodule
bind ljr_regs ljr_regs_sva #(.NSRC(NSRC), .SEC_CYCLES(SEC_CYCLES)) u_sva (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .chan_irq_src_in(chan_irq_src_in),
    .tx_atten_enable_out(tx_atten_enable_out),
    .tx_atten_fifo_depth_out(tx_atten_fifo_depth_out),
    .tx_atten_fifo_bits_out(tx_atten_fifo_bits_out),
    .tx_atten_corner_select_out(tx_atten_corner_select_out),
    .tx_atten_fill_limit_out(tx_atten_fill_limit_out),
    .channel_soft_reset_out(channel_soft_reset_out),
    .chan_irq_flag_out(chan_irq_flag_out), .irq_out(irq_out));
`default_nettype wire

// [ljr_regs_tb.sv]
// Purpose: self-checking bench of the register bank
// Assumes: host model drives the register port, sources driven here
// Notes: second timer shortened to 50 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module ljr_regs_tb;
    localparam int NSRC = 4;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [10:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic [ljr_pkg::NCH*NSRC-1:0] src = '0;
    logic [21:0] en;
    logic [21:0] crn;
    logic [21:0] lim;
    logic [21:0] srst;
    logic [21:0] flag;
    logic [43:0] dp;
    logic [175:0] fbits;
    logic irq;
    logic [7:0] d;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #25 sys_clk_in = ~sys_clk_in;
    ljr_host u_host (.sys_clk_in(sys_clk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));
    ljr_regs #(.NSRC(NSRC), .SEC_CYCLES(50)) u_dut (.sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .chan_irq_src_in(src),
        .tx_atten_enable_out(en), .tx_atten_fifo_depth_out(dp),
        .tx_atten_fifo_bits_out(fbits), .tx_atten_corner_select_out(crn),
        .tx_atten_fill_limit_out(lim), .channel_soft_reset_out(srst),
        .chan_irq_flag_out(flag), .irq_out(irq));
    // read and compare
    task automatic rd_chk(input logic [10:0] a, input logic [7:0] e);
        logic [7:0] got;
        u_host.rd_reg(a, got);
        `CHK(got, e)
    endtask
    task automatic test_reset_values();
        rd_chk(11'h002, 8'h00);
        rd_chk(11'h7c2, 8'h00);
        rd_chk(11'h340, 8'h00);
        rd_chk(11'h380, 8'h00);
        rd_chk(11'h3c0, 8'h00);
        rd_chk(11'h600, 8'h00);
        `CHK({en, crn, lim, dp}, 110'h0)
    endtask
    task automatic test_atten();
        logic [7:0] v;
        logic [7:0] fb [4] = '{8'h80, 8'h40, 8'h20, 8'h20};
        for (int k = 0; k < 4; k++) begin
            v = 8'he8 | 8'(k << 1) | (k[0] ? 8'h11 : 8'h00);
            u_host.wr_reg(11'h7c2, v);
            rd_chk(11'h7c2, v & 8'h1f);
            `CHK(dp[1:0], 2'(k))
            `CHK(fbits[7:0], fb[k])
            `CHK({lim[0], en[0], crn[0]}, {v[4], 1'b1, v[0]})
        end
        u_host.wr_reg(11'h502, 8'h08);
        rd_chk(11'h502, 8'h08);
        `CHK(en, 22'h200001)
    endtask
    task automatic test_summary();
        @(posedge sys_clk_in);
        src[0] <= 1'b1;
        src[9*NSRC+2] <= 1'b1;
        src[17*NSRC+3] <= 1'b1;
        src[21*NSRC+1] <= 1'b1;
        rd_chk(11'h340, 8'h11);
        rd_chk(11'h380, 8'h80);
        rd_chk(11'h300, 8'h01);
        `CHK(flag, 22'h220201)
        u_host.wr_reg(11'h340, 8'hff);
        rd_chk(11'h340, 8'h11);
        @(posedge sys_clk_in);
        src <= '0;
        rd_chk(11'h340, 8'h00);
        rd_chk(11'h380, 8'h00);
    endtask
    task automatic test_soft_reset();
        int n;
        u_host.wr_reg(11'h101, 8'h00);
        repeat (2) @(posedge sys_clk_in);
        `CHK(srst, 22'h0)
        u_host.wr_reg(11'h101, 8'h02);
        rd_chk(11'h101, 8'h02);
        `CHK(srst, 22'h000020)
        n = 2;
        while (srst[5] === 1'b1 && n < 40) begin
            @(posedge sys_clk_in);
            n++;
        end
        `CHK(n <= 20, 1'b1)
        rd_chk(11'h101, 8'h00);
    endtask
    task automatic test_irq();
        u_host.rd_reg(11'h7e0, d);
        @(posedge sys_clk_in);
        src[3*NSRC] <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        `CHK(irq, 1'b0)
        u_host.wr_reg(11'h7e4, 8'h02);
        rd_chk(11'h7e4, 8'h02);
        `CHK(irq, 1'b1)
        u_host.rd_reg(11'h7e0, d);
        `CHK(d[1], 1'b1)
        `CHK(irq, 1'b0)
    endtask
    task automatic test_timer();
        logic [7:0] t;
        int n;
        n = 0;
        u_host.wr_reg(11'h3c0, 8'h01);
        u_host.rd_reg(11'h3c0, t);
        while (t[0] !== 1'b1 && n < 30) begin
            u_host.rd_reg(11'h3c0, t);
            n++;
        end
        `CHK(t, 8'h01)
        u_host.wr_reg(11'h3c0, 8'h00);
        rd_chk(11'h3c0, 8'h01);
        u_host.wr_reg(11'h3c0, 8'h01);
        rd_chk(11'h3c0, 8'h00);
    endtask
    // print counts and verdict, then stop
    task automatic complete_run();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        test_reset_values();
        test_atten();
        test_summary();
        test_soft_reset();
        test_irq();
        test_timer();
        complete_run();
    end
    // hang guard
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end
endmodule
`default_nettype wire

// [ljr_sec_timer.sv]
// Purpose: one-second tick generator
// Assumes: single clock; CYCLES is the number of clocks per second
// Notes: tick is a registered one-cycle pulse in the cycle after the last count

`timescale 1ns/1ps
`default_nettype none

module ljr_sec_timer #(
    parameter int CYCLES = ljr_pkg::SEC_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // tick
    output logic tick_out
);

    generate
        if (CYCLES < 2) begin : g_bad
            $error("ljr_sec_timer: CYCLES must be at least 2");
        end
    endgenerate

    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic last_w;

    // wrap on the last count
    assign last_w = (cnt_r == 32'(CYCLES - 1));
    assign cnt_nxt = last_w ? 32'h0 : cnt_r + 32'h1;

    // count clocks
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= 32'h0;
            tick_out <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_out <= last_w;
        end
    end

endmodule

`default_nettype wire
